// ===== design/lpm_defs.svh
// Constants for the low-power mode controller: timer control bit positions,
// stabilization counts and reset values. Included by the package and modules.
// Behaviour
// - Build option picks stop or halt for sleep
// - Stop mode switches the oscillator off
// - Stop entry clears timer flags and enables
// - Sleep clears interrupt mask, sets external enable
// - Stop mode keeps all other state
// - Stop exits on external, port irq, reset
// - Stop exit waits stabilization count before clocks
// - Halt stops core clock, timer clocks run
// - Halt keeps oscillator and watchdog running
// - Halt exits on timer, external irq, reset
// - Halt exit delay bounded by selected count
// - Wait stops core clock, timer clocks run
// - Wait clears interrupt mask, sets external enable
// - Wait exits on timer, external irq, reset
// - Enabled watchdog timeout resets, even in wait
// - Watchdog plus stop allowed: sleep stops oscillator
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

// Bit positions inside the timer status/control byte
`define LPM_TSC_OVF_FLAG_BIT 7
`define LPM_TSC_TICK_FLAG_BIT 6
`define LPM_TSC_OVF_IE_BIT 5
`define LPM_TSC_TICK_IE_BIT 4
`define LPM_TSC_CLEAR_MASK 8'h0f

// Oscillator stabilization counts in core clock cycles
`define LPM_STAB_SHORT 12'h010
`define LPM_STAB_LONG 12'hfe0
`define LPM_STAB_W 12

`define LPM_EXT_IRQ_EN_RESET 1'b0
`define LPM_TSC_RESET 8'h00

`endif

// ===== design/lpm_pkg.sv
// Types shared by the low-power mode controller files.
// Assumes lpm_defs.svh is on the include path.
`include "lpm_defs.svh"

package lpm_pkg;

  typedef enum logic [4:0] {
    LPM_RUN = 5'b00001,
    LPM_WAIT = 5'b00010,
    LPM_HALT = 5'b00100,
    LPM_STOP = 5'b01000,
    LPM_STAB = 5'b10000
  } lpm_state_e;

  // Wake sources as seen by the controller
  typedef struct packed {
    logic ext_irq;
    logic port_irq;
    logic timer_irq;
    logic ext_reset;
  } lpm_wake_s;

  // Mask-style build options
  typedef struct packed {
    logic stop_enable;
    logic long_stab;
    logic port_irq_enable;
    logic watchdog_enable;
  } lpm_opt_s;

endpackage

// ===== design/lpm_stab_counter.sv
// Oscillator stabilization counter: counts core clock cycles from start
// and reports done once the selected terminal count is reached.
// Assumes start is a one-cycle pulse from the controller.
`timescale 1ns/1ps
`include "lpm_defs.svh"

module lpm_stab_counter #(
  parameter int W = `LPM_STAB_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [W-1:0] terminal,
  output logic done
);
  import lpm_pkg::*;

  logic [W-1:0] count_reg;
  logic run_reg;

  initial begin
    if (W < 12) $error("lpm_stab_counter: W too small for counts");
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
      run_reg <= 1'b0;
    end else if (start) begin
      count_reg <= '0;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      count_reg <= count_reg + 1'b1;
      if (count_reg == terminal - 1'b1) begin
        run_reg <= 1'b0;
      end
    end
  end

  assign done = run_reg && (count_reg == terminal - 1'b1);
endmodule

// ===== design/lpm_watchdog.sv
// Watchdog counter: clears on service, times out after a count of cycles,
// freezes while the oscillator is off.
// Assumes osc_run low means no clock is available to it.
`timescale 1ns/1ps
`include "lpm_defs.svh"

module lpm_watchdog #(
  parameter int TIMEOUT = 65536
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic osc_run,
  input wire logic service,
  output logic timeout
);
  import lpm_pkg::*;

  localparam int CW = $clog2(TIMEOUT);
  logic [CW-1:0] count_reg;

  initial begin
    if (TIMEOUT < 2) $error("lpm_watchdog: TIMEOUT must be at least 2");
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
    end else if (!enable || service || timeout) begin
      count_reg <= '0;
    end else if (osc_run) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Counts in wait and halt too, so long waits will trip it
  assign timeout = enable && osc_run && (count_reg == CW'(TIMEOUT - 1));
endmodule

// ===== design/lpm_ctrl.sv
// Low-power mode controller: sleep and wait instructions, entry side
// effects, wake-up sources, oscillator gating and stabilization delay.
// Assumes the core pulses sleep_exec/wait_exec once per instruction and
// holds its state while core_clk_en is low.
`timescale 1ns/1ps
`include "lpm_defs.svh"

module lpm_ctrl #(
  parameter int STAB_W = `LPM_STAB_W,
  parameter int WDOG_TIMEOUT = 65536
) (
  input wire logic clk,
  input wire logic reset,
  input wire lpm_pkg::lpm_opt_s opts,
  input wire logic sleep_exec,
  input wire logic wait_exec,
  input wire lpm_pkg::lpm_wake_s wake,
  input wire logic watchdog_service,
  input wire logic [7:0] timer_status_control_in,
  output logic [7:0] timer_status_control,
  output logic tsc_write,
  output logic irq_mask_clear,
  output logic ext_irq_enable,
  output logic osc_enable,
  output logic core_clk_en,
  output logic timer_clk_en,
  output logic watchdog_reset,
  output lpm_pkg::lpm_state_e mode
);
  import lpm_pkg::*;

  lpm_state_e state_reg;
  lpm_state_e state_next;
  logic stab_start;
  logic stab_done;
  logic wdog_timeout;
  logic [STAB_W-1:0] stab_terminal;
  logic stop_wake;
  logic run_wake;

  initial begin
    if (STAB_W < 12) $error("lpm_ctrl: STAB_W cannot hold the long count");
  end

  function automatic logic [STAB_W-1:0] stab_count(input logic long_sel);
    stab_count = long_sel ? STAB_W'(`LPM_STAB_LONG) : STAB_W'(`LPM_STAB_SHORT);
  endfunction

  assign stab_terminal = stab_count(opts.long_stab);

  // Port interrupt only counts when its option is fitted
  assign stop_wake = wake.ext_irq || (opts.port_irq_enable && wake.port_irq)
    || wake.ext_reset;
  assign run_wake = wake.timer_irq || wake.ext_irq || wake.ext_reset;

  always_comb begin
    state_next = state_reg;
    stab_start = 1'b0;
    unique case (state_reg)
      LPM_RUN: begin
        if (sleep_exec && opts.stop_enable) begin
          state_next = LPM_STOP;
        end else if (sleep_exec) begin
          state_next = LPM_HALT;
        end else if (wait_exec) begin
          state_next = LPM_WAIT;
        end
      end
      LPM_WAIT: begin
        if (run_wake) begin
          state_next = LPM_RUN;
        end
      end
      LPM_HALT: begin
        if (run_wake) begin
          state_next = LPM_STAB;
          stab_start = 1'b1;
        end
      end
      LPM_STOP: begin
        if (stop_wake) begin
          state_next = LPM_STAB;
          stab_start = 1'b1;
        end
      end
      LPM_STAB: begin
        if (stab_done) begin
          state_next = LPM_RUN;
        end
      end
      default: state_next = LPM_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= LPM_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Clock gating outputs registered from the next state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_enable <= 1'b1;
      core_clk_en <= 1'b1;
      timer_clk_en <= 1'b1;
      mode <= LPM_RUN;
    end else begin
      osc_enable <= (state_next != LPM_STOP);
      core_clk_en <= (state_next == LPM_RUN);
      timer_clk_en <= (state_next != LPM_STOP) && (state_next != LPM_STAB);
      mode <= state_next;
    end
  end

  // Entry side effects; only the named bits move, the rest pass through
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_status_control <= `LPM_TSC_RESET;
      tsc_write <= 1'b0;
    end else begin
      tsc_write <= 1'b0;
      if (state_reg == LPM_RUN && state_next == LPM_STOP) begin
        timer_status_control <= timer_status_control_in & `LPM_TSC_CLEAR_MASK;
        tsc_write <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_mask_clear <= 1'b0;
      ext_irq_enable <= `LPM_EXT_IRQ_EN_RESET;
    end else begin
      irq_mask_clear <= (state_reg == LPM_RUN) && (sleep_exec || wait_exec);
      if ((state_reg == LPM_RUN) && (sleep_exec || wait_exec)) begin
        ext_irq_enable <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wdog_timeout;
    end
  end

  lpm_stab_counter #(
    .W(STAB_W)
  ) u_stab (
    .clk(clk),
    .reset(reset),
    .start(stab_start),
    .terminal(stab_terminal),
    .done(stab_done)
  );

  lpm_watchdog #(
    .TIMEOUT(WDOG_TIMEOUT)
  ) u_wdog (
    .clk(clk),
    .reset(reset),
    .enable(opts.watchdog_enable),
    .osc_run(state_reg != LPM_STOP),
    .service(watchdog_service),
    .timeout(wdog_timeout)
  );
endmodule

// ===== verif/lpm_ctrl_monitor.sv
// Port-level checker for the low-power mode controller.
// Assumes lpm_pkg is compiled first and a single 125 MHz clock.
`timescale 1ns/1ps
module lpm_ctrl_monitor
  import lpm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire lpm_pkg::lpm_opt_s opts,
  input wire logic sleep_exec,
  input wire logic wait_exec,
  input wire lpm_pkg::lpm_wake_s wake,
  input wire logic [7:0] timer_status_control_in,
  input wire logic [7:0] timer_status_control,
  input wire logic tsc_write,
  input wire logic irq_mask_clear,
  input wire logic ext_irq_enable,
  input wire logic osc_enable,
  input wire logic core_clk_en,
  input wire logic timer_clk_en,
  input wire logic watchdog_reset,
  input wire lpm_pkg::lpm_state_e mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [11:0] stab_cnt;
  wire logic [11:0] term = opts.long_stab ? 12'hfe0 : 12'h010;
  wire logic run = mode == LPM_RUN;
  // Cycles spent in stabilization, compared on the way out
  always_ff @(posedge clk or posedge reset)
    if (reset) stab_cnt <= 12'h000;
    else stab_cnt <= (mode == LPM_STAB) ? stab_cnt + 12'h001 : 12'h000;
  a_stop_entry_tsc: assert property (run && sleep_exec && opts.stop_enable |=>
    mode == LPM_STOP && tsc_write && timer_status_control == ($past(timer_status_control_in) & 8'h0f))
    else $error("stop entry side effects wrong");
  a_halt_entry: assert property (run && sleep_exec && !opts.stop_enable |=>
    mode == LPM_HALT && osc_enable && !tsc_write) else $error("halt entry wrong");
  a_mask_clear: assert property (run && (sleep_exec || wait_exec) |=>
    irq_mask_clear && ext_irq_enable) else $error("mask clear missing");
  a_stop_clocks_off: assert property (mode == LPM_STOP |->
    !osc_enable && !core_clk_en && !timer_clk_en) else $error("clocks run in stop");
  a_idle_clocks: assert property (mode inside {LPM_WAIT, LPM_HALT} |->
    !core_clk_en && timer_clk_en && osc_enable) else $error("idle clocks wrong");
  a_stop_hold: assert property (mode == LPM_STOP && !wake.ext_irq && !wake.ext_reset &&
    !(wake.port_irq && opts.port_irq_enable) |=> mode == LPM_STOP) else $error("stop left");
  a_stop_wake: assert property (mode == LPM_STOP && wake.ext_irq |=>
    mode == LPM_STAB) else $error("stop not woken");
  a_wait_wake: assert property (mode == LPM_WAIT && (wake.ext_irq || wake.timer_irq) |=>
    run && core_clk_en) else $error("wait not woken");
  a_halt_wake: assert property (mode == LPM_HALT && wake.timer_irq |=>
    mode == LPM_STAB) else $error("halt not woken");
  a_stab_gate: assert property (mode == LPM_STAB |-> !core_clk_en)
    else $error("core clock during stabilization");
  a_stab_len: assert property (mode == LPM_STAB ##1 run |-> stab_cnt == term)
    else $error("stabilization count wrong");
  a_stop_no_wdog: assert property (mode == LPM_STOP |-> !watchdog_reset)
    else $error("watchdog fired in stop");
endmodule

bind lpm_ctrl lpm_ctrl_monitor i_mon (.*);

// ===== verif/lpm_far_model.sv
// Far-side stand-in: timer status/control byte and its gated request.
// Assumes the bench loads the byte; the controller writes it on stop entry.
`timescale 1ns/1ps
module lpm_far_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic tsc_write,
  input wire logic [7:0] tsc_wr_val,
  output logic [7:0] tsc,
  output logic timer_irq
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) tsc <= 8'h00;
    else if (tsc_write) tsc <= tsc_wr_val;
    else if (load) tsc <= load_val;
  end
  // Request only while its own enable is set
  assign timer_irq = (tsc[7] & tsc[5]) | (tsc[6] & tsc[4]);
endmodule

// ===== verif/tb_low_power_mode_control.sv
// Bench for the low-power mode controller: sleep, wait, wakes, watchdog.
// Assumes lpm_ctrl_monitor is bound and the far side is lpm_far_model.
`timescale 1ns/1ps
module tb_low_power_mode_control;
  import lpm_pkg::*;
  logic clk = 0, reset = 1, sleep_exec = 0, wait_exec = 0, load = 0;
  logic ext_irq = 0, port_irq = 0, hit;
  logic [7:0] load_val = 8'h00, tsc_in, tsc_out;
  logic tsc_write, irq_mask_clear, ext_irq_enable, osc_enable, core_clk_en, timer_clk_en;
  logic watchdog_reset, timer_irq;
  lpm_opt_s opts = '0;
  lpm_state_e mode;
  int bad_count = 0, samples_checked = 0, n;
  always #4 clk = ~clk;
  lpm_ctrl #(.WDOG_TIMEOUT(16)) i_dut (.clk, .reset, .opts, .sleep_exec, .wait_exec,
    .wake({ext_irq, port_irq, timer_irq, 1'b0}), .watchdog_service(1'b0),
    .timer_status_control_in(tsc_in), .timer_status_control(tsc_out), .tsc_write,
    .irq_mask_clear, .ext_irq_enable, .osc_enable, .core_clk_en, .timer_clk_en,
    .watchdog_reset, .mode);
  lpm_far_model i_far (.clk, .reset, .load, .load_val, .tsc_write, .tsc_wr_val(tsc_out),
    .tsc(tsc_in), .timer_irq);
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic restart(input lpm_opt_s o);
    reset <= 1;
    opts <= o;
    repeat (16) @(posedge clk);
    reset <= 0;
    @(posedge clk);
  endtask
  task automatic exec(input logic slp);
    @(posedge clk);
    sleep_exec <= slp;
    wait_exec <= !slp;
    @(posedge clk);
    sleep_exec <= 0;
    wait_exec <= 0;
    #1;
    chk(irq_mask_clear, 1);
    chk(ext_irq_enable, 1);
  endtask
  // Raises {ext, port, timer} and counts cycles until the core clock returns
  task automatic rouse(input logic [2:0] src, output int cyc);
    @(posedge clk);
    {ext_irq, port_irq, load} <= src;
    load_val <= 8'h50;
    cyc = 0;
    while (core_clk_en !== 1 && cyc < 5000) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
    @(posedge clk);
    {ext_irq, port_irq} <= 2'b00;
    load_val <= 8'h00;
    load <= 1;
    @(posedge clk);
    load <= 0;
  endtask
  task automatic watch(input int cyc);
    hit = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      hit |= watchdog_reset;
    end
  endtask
  initial begin
    restart(4'b1000);
    load_val <= 8'hff;
    load <= 1;
    @(posedge clk);
    load <= 0;
    exec(1);
    chk(mode, LPM_STOP);
    chk(osc_enable, 0);
    chk(tsc_write, 1);
    chk(tsc_out, 8'h0f);
    @(posedge clk);
    load_val <= 8'ha0;
    load <= 1;
    port_irq <= 1;
    @(posedge clk);
    load <= 0;
    repeat (4) @(posedge clk);
    #1;
    chk(mode, LPM_STOP);
    rouse(3'b100, n);
    chk(n, 17);
    restart(4'b0110);
    exec(1);
    chk(mode, LPM_HALT);
    chk(osc_enable, 1);
    chk(timer_clk_en, 1);
    rouse(3'b001, n);
    // One extra cycle: the timer request follows the far-side load
    chk(n, 4066);
    exec(0);
    chk(mode, LPM_WAIT);
    @(posedge clk);
    port_irq <= 1;
    repeat (4) @(posedge clk);
    #1;
    chk(mode, LPM_WAIT);
    rouse(3'b001, n);
    chk(n, 2);
    restart(4'b1010);
    exec(1);
    rouse(3'b010, n);
    chk(n, 17);
    restart(4'b0001);
    exec(0);
    watch(40);
    chk(hit, 1);
    restart(4'b1001);
    exec(1);
    watch(64);
    chk(hit, 0);
    give_verdict();
  end
endmodule
